// *** logic/psw_pkg.sv ***
// Constants for the program status execution-state block
//
// Behaviour
// RULE1: Branch to even target clears state bit
// RULE2: Exception return reloads state bit from stack
// RULE3: Entry or reset loads state bit from vector
// RULE4: Executing with state bit clear faults or locks
// RULE5: State bits shown only in combined/execution views
// RULE6: Bits 23:16 and 9:6 read zero
// RULE7: Resumable/conditional state split over 15:10, 26:25
// RULE8: Interrupted multiple transfer records next register
// RULE9: Return resumes transfer at recorded register
// RULE10: Bits 11:10 zero while holding transfer state
// RULE11: Track conditional block of up to four
// RULE12: Active exception number in bits 5:0
// RULE13: Software writes to state fields are ignored
`default_nettype none
package psw_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMBINED   = 8'h00;
    localparam logic [7:0] OFS_EXEC_VIEW  = 8'h04;
    localparam logic [7:0] OFS_INT_VIEW   = 8'h08;
    localparam logic [7:0] OFS_CONTROL    = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STATE_HI_MSB  = 26;
    localparam int STATE_HI_LSB  = 25;
    localparam int ISA_POS       = 24;
    localparam int STATE_LO_MSB  = 15;
    localparam int STATE_LO_LSB  = 10;
    localparam int EXC_NUM_MSB   = 5;
    localparam int CTRL_LOCK_POS = 0;
    localparam int STAT_LOCK_POS = 0;
    localparam int STAT_IT_POS   = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       ISA_RST     = 1'b1;
    localparam logic [7:0] STATE_RST   = 8'h00;
    localparam logic [5:0] EXC_NUM_RST = 6'h00;

    // ------------------------------------------------------------
    // Exception numbers
    // ------------------------------------------------------------
    localparam logic [5:0] EXC_THREAD  = 6'h00;
    localparam logic [5:0] EXC_NMI     = 6'h02;
    localparam logic [5:0] EXC_HARD    = 6'h03;
    localparam logic [5:0] EXC_IRQ0    = 6'h10;
    localparam logic [5:0] EXC_IRQ_MAX = 6'h3b;

    // Kind of program-counter write that may change the state bit
    typedef enum logic [1:0]
    {
        BR_NONE,
        BR_EXCHANGE,
        BR_LINK_EXCHANGE,
        BR_STACK_RESTORE
    } branch_kind_e;

endpackage
`default_nettype wire

// *** logic/exec_state_if.sv ***
// Carrier between the status word block and its state tracker
`timescale 1ns/100ps
`default_nettype none
interface exec_state_if;
    logic       mt_suspend;   // Interrupt stops a multiple transfer
    logic [3:0] mt_next_reg;  // Next register operand of that transfer
    logic       mt_done;      // Multiple transfer completed
    logic       it_start;     // 16-bit if-then issued
    logic [7:0] it_value;     // Condition and mask of that if-then
    logic       it_advance;   // One block instruction retired
    logic       restore;      // Exception return reload
    logic [7:0] restore_value;
    logic [7:0] state;        // Resumable or conditional state
    logic       resume_valid; // Resume a transfer after return
    logic [3:0] resume_reg;

    modport ctrl
    (
        output mt_suspend, mt_next_reg, mt_done, it_start, it_value,
        output it_advance, restore, restore_value,
        input  state, resume_valid, resume_reg
    );
    modport track
    (
        input  mt_suspend, mt_next_reg, mt_done, it_start, it_value,
        input  it_advance, restore, restore_value,
        output state, resume_valid, resume_reg
    );
endinterface
`default_nettype wire

// *** logic/exec_state_track.sv ***
// Tracker of the resumable-transfer or conditional-block state
`timescale 1ns/100ps
`default_nettype none
module exec_state_track
    import psw_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rstn,
    exec_state_if.track es
);

    logic [7:0] state_ff;
    logic [7:0] nxt_state;
    logic       resume_ff;
    logic [3:0] resume_reg_ff;
    logic       restored_xfer;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Transfer state has the low four bits clear and the upper four bits nonzero
    assign restored_xfer = (es.restore_value[3:0] == 4'h0) && (es.restore_value[7:4] != 4'h0);

    // Return beats suspend beats if-then beats advance
    always_comb
    begin
        nxt_state = state_ff;
        if (es.restore)
            nxt_state = es.restore_value;                     // RULE9
        else if (es.mt_suspend)
            nxt_state = {es.mt_next_reg, 4'h0};               // RULE8 RULE10
        else if (es.it_start)
            nxt_state = es.it_value;                          // RULE11
        else if (es.it_advance)
        begin
            if (state_ff[2:0] == 3'h0)
                nxt_state = STATE_RST;                        // RULE11
            else
                nxt_state = {state_ff[7:5], state_ff[3:0], 1'b0};
        end
        else if (es.mt_done)
            nxt_state = STATE_RST;
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= STATE_RST;
        else
            state_ff <= nxt_state;                            // RULE7
    end

    // Resume request after return into a suspended transfer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            resume_ff     <= 1'b0;
            resume_reg_ff <= 4'h0;
        end
        else
        begin
            resume_ff <= es.restore && restored_xfer;        // RULE9
            if (es.restore && restored_xfer)
                resume_reg_ff <= es.restore_value[7:4];      // RULE9
        end
    end

    assign es.state        = state_ff;
    assign es.resume_valid = resume_ff;
    assign es.resume_reg   = resume_reg_ff;

endmodule
`default_nettype wire

// *** logic/psw_exec_state.sv ***
// Execution and interrupt state of the program status word
`timescale 1ns/100ps
`default_nettype none
module psw_exec_state
    import psw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Program counter writes
    input  wire logic        branch_valid,
    input  wire logic [1:0]  branch_kind,
    input  wire logic [31:0] branch_target,
    // Exception entry and reset vector fetch
    input  wire logic        vector_valid,
    input  wire logic [31:0] vector_value,
    input  wire logic [5:0]  entry_number,
    // Exception return
    input  wire logic        return_valid,
    input  wire logic [31:0] stacked_status_word,
    input  wire logic [5:0]  return_number,
    // Instruction execution
    input  wire logic        exec_attempt,
    input  wire logic        mt_suspend,
    input  wire logic [3:0]  mt_next_reg,
    input  wire logic        mt_done,
    input  wire logic        it_start,
    input  wire logic [7:0]  it_value,
    input  wire logic        it_advance,
    // Core-facing results
    output logic [31:0]      program_status_word,
    output logic             state_fault,
    output logic             lockup,
    output logic             resume_valid,
    output logic [3:0]       resume_reg,
    output logic             in_it_block,
    output logic [3:0]       it_cond
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic        isa_ff;
    logic [5:0]  exc_num_ff;
    logic        fault_ff;
    logic        lockup_ff;
    logic        lock_sel_ff;
    logic [31:0] psw_ff;
    logic        resume_ff;
    logic [3:0]  resume_reg_ff;
    logic        in_it_ff;
    logic [3:0]  it_cond_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;
    logic        hresp_ff;
    logic        nxt_isa;
    logic [5:0]  nxt_exc_num;
    logic        is_exchange;
    logic        bad_exec;
    logic        escalate;
    logic        bus_take;
    logic [31:0] rd_mux;
    logic [31:0] combined_view;
    logic [31:0] exec_view;
    logic [31:0] int_view;
    logic [7:0]  stacked_state;

    exec_state_if es ();

    // ------------------------------------------------------------
    // State tracker
    // ------------------------------------------------------------
    // Stacked word gives back both halves of the split state field
    assign stacked_state = {stacked_status_word[STATE_LO_MSB:STATE_LO_LSB],
                            stacked_status_word[STATE_HI_MSB:STATE_HI_LSB]};

    // Core events routed to the tracker
    assign es.mt_suspend    = mt_suspend;
    assign es.mt_next_reg   = mt_next_reg;
    assign es.mt_done       = mt_done;
    assign es.it_start      = it_start;
    assign es.it_value      = it_value;
    assign es.it_advance    = it_advance;
    assign es.restore       = return_valid;
    assign es.restore_value = stacked_state;

    exec_state_track u_track
    (
        .clk  (clk),
        .rstn (rstn),
        .es   (es.track)
    );

    // ------------------------------------------------------------
    // Instruction-set state bit
    // ------------------------------------------------------------
    // Only exchange-style program counter writes touch the bit
    assign is_exchange = branch_valid && (branch_kind != BR_NONE);

    // Vector load beats return beats branch
    always_comb
    begin
        nxt_isa = isa_ff;
        if (vector_valid)
            nxt_isa = vector_value[0];                        // RULE3
        else if (return_valid)
            nxt_isa = stacked_status_word[ISA_POS];           // RULE2
        else if (is_exchange)
            nxt_isa = branch_target[0];                       // RULE1
    end

    // State bit register, only core events change it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            isa_ff <= ISA_RST;
        else
            isa_ff <= nxt_isa;                                // RULE13
    end

    // ------------------------------------------------------------
    // Active exception number
    // ------------------------------------------------------------
    // Entry takes the new number, return takes the one below
    always_comb
    begin
        nxt_exc_num = exc_num_ff;
        if (vector_valid)
            nxt_exc_num = entry_number;                       // RULE12
        else if (return_valid)
            nxt_exc_num = return_number;                      // RULE12
    end

    // Exception number register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            exc_num_ff <= EXC_NUM_RST;
        else
            exc_num_ff <= nxt_exc_num;
    end

    // ------------------------------------------------------------
    // Fault and lockup on a cleared state bit
    // ------------------------------------------------------------
    // No instruction may run while the bit is clear
    assign bad_exec = exec_attempt && !isa_ff;
    // Already in the top handlers, or software chose lockup
    assign escalate = lock_sel_ff || (exc_num_ff == EXC_HARD) || (exc_num_ff == EXC_NMI);

    // Fault request pulse
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            fault_ff <= 1'b0;
        else
            fault_ff <= bad_exec && !escalate;                // RULE4
    end

    // Lockup holds until reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lockup_ff <= 1'b0;
        else if (bad_exec && escalate)
            lockup_ff <= 1'b1;                                // RULE4
    end

    // ------------------------------------------------------------
    // Status views
    // ------------------------------------------------------------
    // Combined view carries state bit, split field and number
    always_comb
    begin
        combined_view = 32'h0000_0000;                        // RULE6
        combined_view[STATE_HI_MSB:STATE_HI_LSB] = es.state[1:0];
        combined_view[ISA_POS] = isa_ff;
        combined_view[STATE_LO_MSB:STATE_LO_LSB] = es.state[7:2];
        combined_view[EXC_NUM_MSB:0] = exc_num_ff;
    end

    // Execution view drops the number, interrupt view keeps only it
    always_comb
    begin
        exec_view = combined_view;                            // RULE5
        exec_view[EXC_NUM_MSB:0] = 6'h00;
        int_view = 32'h0000_0000;
        int_view[EXC_NUM_MSB:0] = exc_num_ff;                 // RULE5 RULE12
    end

    // Combined word registered for the core
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            psw_ff <= {7'h00, ISA_RST, 24'h00_0000};
        else
            psw_ff <= combined_view;
    end

    // Conditional block and resume outputs registered
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            resume_ff     <= 1'b0;
            resume_reg_ff <= 4'h0;
            in_it_ff      <= 1'b0;
            it_cond_ff    <= 4'h0;
        end
        else
        begin
            resume_ff     <= es.resume_valid;                 // RULE9
            resume_reg_ff <= es.resume_reg;
            in_it_ff      <= (es.state[3:0] != 4'h0);         // RULE11
            it_cond_ff    <= es.state[7:4];
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Address phase accepted on a selected non-idle transfer
    assign bus_take = hsel && htrans[1] && hready;

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (haddr[7:0])
            OFS_COMBINED:  rd_mux = combined_view;
            OFS_EXEC_VIEW: rd_mux = exec_view;
            OFS_INT_VIEW:  rd_mux = int_view;
            OFS_CONTROL:   rd_mux = {31'h0, lock_sel_ff};
            OFS_STATUS:    rd_mux = {30'h0, in_it_ff, lockup_ff};
            default:       rd_mux = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000)
            rd_mux = 32'h0000_0000;
    end

    // Read data captured in the address phase, valid in data phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hrdata_ff <= 32'h0000_0000;
        else if (bus_take && !hwrite)
            hrdata_ff <= rd_mux;
    end

    // Write address phase remembered for the data phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_ff <= bus_take && hwrite && (haddr[31:8] == 24'h00_0000);
            wr_addr_ff <= haddr[7:0];
        end
    end

    // Only the control word is writable; status fields stay put
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lock_sel_ff <= 1'b0;
        else if (wr_pend_ff && (wr_addr_ff == OFS_CONTROL))
            lock_sel_ff <= hwdata[CTRL_LOCK_POS];             // RULE13
    end

    // Zero wait states, always OKAY
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
        else
        begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata              = hrdata_ff;
    assign hreadyout           = hreadyout_ff;
    assign hresp               = hresp_ff;
    assign program_status_word = psw_ff;
    assign state_fault         = fault_ff;
    assign lockup              = lockup_ff;
    assign resume_valid        = resume_ff;
    assign resume_reg          = resume_reg_ff;
    assign in_it_block         = in_it_ff;
    assign it_cond             = it_cond_ff;

endmodule
`default_nettype wire

// *** testbench/psw_exec_state_assertions.sv ***
// Concurrent checks on the status word block ports
`timescale 1ns/100ps
`default_nettype none
module psw_exec_state_assertions
    import psw_pkg::*;
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        branch_valid,
    input wire logic [1:0]  branch_kind,
    input wire logic [31:0] branch_target,
    input wire logic        vector_valid,
    input wire logic [31:0] vector_value,
    input wire logic [5:0]  entry_number,
    input wire logic        return_valid,
    input wire logic [31:0] stacked_status_word,
    input wire logic [5:0]  return_number,
    input wire logic        exec_attempt,
    input wire logic        mt_suspend,
    input wire logic [3:0]  mt_next_reg,
    input wire logic        it_start,
    input wire logic [7:0]  it_value,
    input wire logic [31:0] program_status_word,
    input wire logic        state_fault,
    input wire logic        lockup,
    input wire logic        resume_valid,
    input wire logic [3:0]  resume_reg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Short alias of the combined view
    wire [31:0] psw = program_status_word;

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence s_restore_xfer;
        return_valid && !vector_valid && stacked_status_word[15:12] != 4'h0
            && stacked_status_word[11:10] == 2'b00 && stacked_status_word[26:25] == 2'b00;
    endsequence
    sequence s_resumed;
        ##2 (resume_valid && resume_reg == $past(stacked_status_word[15:12], 2));
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RESERVED_ZERO: assert property (
        psw[23:16] == 8'h00 && psw[9:6] == 4'h0) else $error("reserved bits set");
    AST_VECTOR_LOAD: assert property (vector_valid |-> ##2
        psw[24] == $past(vector_value[0], 2) && psw[5:0] == $past(entry_number, 2))
        else $error("vector load wrong");
    AST_RETURN_LOAD: assert property (return_valid && !vector_valid |-> ##2
        psw[24] == $past(stacked_status_word[24], 2) && psw[5:0] == $past(return_number, 2))
        else $error("return reload wrong");
    AST_BRANCH_BIT: assert property (
        branch_valid && branch_kind != 2'b00 && !vector_valid && !return_valid
        |-> ##2 psw[24] == $past(branch_target[0], 2)) else $error("branch bit wrong");
    AST_SUSPEND_REG: assert property (mt_suspend && !return_valid |-> ##2
        psw[15:10] == {$past(mt_next_reg, 2), 2'b00} && psw[26:25] == 2'b00)
        else $error("suspend state wrong");
    AST_BLOCK_STATE: assert property (
        it_start && !return_valid && !mt_suspend
        |-> ##2 {psw[15:10], psw[26:25]} == $past(it_value, 2)) else $error("block state wrong");
    AST_RESUME: assert property (s_restore_xfer |-> s_resumed)
        else $error("no resume");
    AST_FAULT: assert property (
        exec_attempt && !psw[24] && !$past(vector_valid || return_valid || branch_valid)
        |-> ##[1:2] (state_fault || lockup)) else $error("no fault");
    AST_FAULT_CAUSE: assert property (
        $rose(state_fault) |-> $past(exec_attempt) || $past(exec_attempt, 2))
        else $error("fault without attempt");
    AST_BIT_HELD: assert property (
        $changed(psw[24]) |-> $past(vector_valid || return_valid || branch_valid, 2))
        else $error("state bit moved");
    AST_NUM_HELD: assert property (
        $changed(psw[5:0]) |-> $past(vector_valid || return_valid, 2))
        else $error("number moved");
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the status word block
`timescale 1ns/100ps
`default_nettype none
module testbench
    import psw_pkg::*;
;
    logic        clk, rstn, hsel, hwrite, branch_valid, vector_valid, return_valid;
    logic        exec_attempt, mt_suspend, mt_done, it_start, it_advance, hit;
    logic [31:0] haddr, hwdata, branch_target, vector_value, stacked_status_word;
    logic [1:0]  htrans, branch_kind;
    logic [2:0]  hsize;
    logic [5:0]  entry_number, return_number;
    logic [3:0]  mt_next_reg, r;
    logic [7:0]  it_value;
    wire  [31:0] hrdata, program_status_word;
    wire         hreadyout, hresp, state_fault, lockup, resume_valid, in_it_block;
    wire  [3:0]  resume_reg, it_cond;
    wire         hready = hreadyout;
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;

    psw_exec_state DUT (.*);

    // Clock and timeout
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            conclude;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mk(input logic t, input logic [7:0] s, input logic [5:0] n);
        return {5'h00, s[1:0], t, 8'h00, s[7:2], 4'h0, n};
    endfunction

    task cmp(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task conclude;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task apply_reset;
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
    endtask

    // One single-word transfer, address phase then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        cmp(exp, d);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
    endtask

    // One-cycle core event of the given kind
    task ev(input int k, input logic [31:0] v, input logic [5:0] n);
        @(posedge clk);
        case (k)
            0: begin vector_valid <= 1'b1; vector_value <= v; entry_number <= n; end
            1: begin return_valid <= 1'b1; stacked_status_word <= v; return_number <= n; end
            2: begin branch_valid <= 1'b1; branch_kind <= n[1:0]; branch_target <= v; end
            3: exec_attempt <= 1'b1;
            4: begin mt_suspend <= 1'b1; mt_next_reg <= v[3:0]; end
            5: mt_done <= 1'b1;
            6: begin it_start <= 1'b1; it_value <= v[7:0]; end
            default: it_advance <= 1'b1;
        endcase
        @(posedge clk);
        {vector_valid, return_valid, branch_valid, exec_attempt} <= 4'h0;
        {mt_suspend, mt_done, it_start, it_advance} <= 4'h0;
    endtask

    task chk_psw(input logic [31:0] exp);
        repeat (2) @(posedge clk);
        cmp(exp, program_status_word);
    endtask

    // Watch the fault pulse, resume pulse or held lockup flag for four cycles
    task poll(input int which);
        hit = 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            if (which == 0 && state_fault === 1'b1) hit = 1'b1;
            if (which == 2 && lockup === 1'b1) hit = 1'b1;
            if (which == 1 && resume_valid === 1'b1)
            begin
                hit = 1'b1;
                r = resume_reg;
            end
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        cmp(32'h0100_0000, program_status_word);
        rd_chk(OFS_COMBINED, mk(1'b1, 8'h00, 6'h00));
        rd_chk(OFS_INT_VIEW, 32'h0);
        rd_chk(OFS_CONTROL, 32'h0);
        rd_chk(8'h20, 32'h0);
    endtask

    task t_numbers;
        static logic [5:0] nums [6] = '{6'h02, 6'h03, 6'h0b, 6'h0f, 6'h10, 6'h3b};
        foreach (nums[i])
        begin
            ev(0, 32'h1, nums[i]);
            chk_psw(mk(1'b1, 8'h00, nums[i]));
        end
        rd_chk(OFS_EXEC_VIEW, mk(1'b1, 8'h00, 6'h00));
        rd_chk(OFS_INT_VIEW, 32'h3b);
    endtask

    task t_branch;
        for (int k = 1; k < 4; k++)
        begin
            ev(0, 32'h1, 6'h10);
            ev(2, 32'h100, k[5:0]);
            chk_psw(mk(1'b0, 8'h00, 6'h10));
        end
        ev(0, 32'h1, 6'h10);
        ev(2, 32'h100, 6'h00);
        chk_psw(mk(1'b1, 8'h00, 6'h10));
        ev(0, 32'h200, 6'h11);
        chk_psw(mk(1'b0, 8'h00, 6'h11));
    endtask

    task t_fault;
        ev(3, 32'h0, 6'h00);
        poll(0);
        cmp(32'h1, {31'h0, hit});
        wr(OFS_CONTROL, 32'h1);
        rd_chk(OFS_CONTROL, 32'h1);
        ev(3, 32'h0, 6'h00);
        poll(2);
        cmp(32'h1, {31'h0, hit});
        rd_chk(OFS_STATUS, 32'h1);
        apply_reset;
        cmp(32'h0, {31'h0, lockup});
        cmp(32'h0100_0000, program_status_word);
        ev(0, 32'h0, EXC_NMI);
        ev(3, 32'h0, 6'h00);
        poll(2);
        cmp(32'h1, {31'h0, hit});
        apply_reset;
    endtask

    task t_write;
        static logic [7:0] ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
        ev(0, 32'h1, 6'h15);
        foreach (ofs[i]) wr(ofs[i], 32'hffff_ffff);
        cmp(32'h2, {30'h0, hreadyout, hresp});
        rd_chk(OFS_COMBINED, mk(1'b1, 8'h00, 6'h15));
        rd_chk(OFS_STATUS, 32'h0);
    endtask

    task t_transfer;
        ev(4, 32'h9, 6'h00);
        chk_psw(mk(1'b1, 8'h90, 6'h15));
        ev(5, 32'h0, 6'h00);
        chk_psw(mk(1'b1, 8'h00, 6'h15));
        ev(1, mk(1'b0, 8'h90, 6'h00), 6'h00);
        poll(1);
        cmp(32'h1, {31'h0, hit});
        cmp(32'h9, {28'h0, r});
        cmp(mk(1'b0, 8'h90, 6'h00), program_status_word);
    endtask

    task t_block;
        ev(0, 32'h1, 6'h00);
        ev(6, 32'h1c, 6'h00);
        chk_psw(mk(1'b1, 8'h1c, 6'h00));
        cmp(32'h1, {31'h0, in_it_block});
        cmp(32'h1, {28'h0, it_cond});
        rd_chk(OFS_STATUS, 32'h2);
        ev(7, 32'h0, 6'h00);
        chk_psw(mk(1'b1, 8'h18, 6'h00));
        ev(7, 32'h0, 6'h00);
        chk_psw(mk(1'b1, 8'h00, 6'h00));
        cmp(32'h0, {31'h0, in_it_block});
    endtask

    // Main sequence
    initial
    begin
        {clk, rstn, hsel, hwrite, branch_valid, vector_valid, return_valid} = '0;
        {exec_attempt, mt_suspend, mt_done, it_start, it_advance, hit, r} = '0;
        {haddr, hwdata, branch_target, vector_value, stacked_status_word} = '0;
        {htrans, branch_kind, entry_number, return_number, mt_next_reg, it_value} = '0;
        hsize = 3'b010;
        apply_reset;
        t_reset;
        t_numbers;
        t_branch;
        t_fault;
        t_write;
        t_transfer;
        t_block;
        conclude;
    end
endmodule

bind psw_exec_state psw_exec_state_assertions u_chk (.*);
`default_nettype wire
